// [hw/psc_pkg.sv]
// Constants, types and helpers of the PID setpoint and actual-value conditioning block
// Behaviour
// RQ1: First setpoint comes from a selectable source; source zero (default) gives zero.
// RQ2: First setpoint is scaled by 0 to 100 %, default 100 %.
// RQ3: Second setpoint has its own source and its own 0 to 100 % scale.
// RQ4: Ramp rises 100 % in the ramp-up time, 0 to 650 s, default 1 s.
// RQ5: Ramp falls 100 % in the ramp-down time, 0 to 650 s, default 1 s.
// RQ6: Ramped setpoint is readable and available as an output.
// RQ7: Setpoint passes a first-order lag, 0 to 60 s, default 0; output available.
// RQ8: Derivative input is actual value when select is 0, deviation when 1.
// RQ9: Actual value comes from a selectable source; source zero is the default.
// RQ10: Actual value passes a first-order lag, 0 to 60 s, default 0; output available.
// RQ11: Limit fault rises when actual value is above the upper limit (default 100 %).
// RQ12: Same fault rises when actual value is below the lower limit (default -100 %).
// RQ13: Actual value is multiplied by a 0 to 500 % gain; 100 % leaves it unchanged.
// RQ14: Function select: 0 pass, 1 square root, 2 square, 3 cube.
// RQ15: Inversion select 1 negates the actual value, 0 leaves it.
// RQ16: Operator picks inversion by disabling the controller and watching actual value versus speed.
// RQ17: Setpoints are summed before the ramp; actual value: filter, limit, gain, function, inversion.
`default_nettype none
package psc_pkg;
	// Values are signed Q16.16 with 1.0 standing for 100 %
	localparam int                 FRAC        = 16;
	localparam logic signed [31:0] FULL_SCALE  = 32'sh0001_0000;
	localparam logic signed [31:0] SAT_MAX     = 32'sh7FFF_FFFF;
	localparam logic signed [31:0] SAT_MIN     = 32'sh8000_0000;
	// Reset values; times are counted in control cycles of one millisecond
	localparam logic [31:0]        SRC_RST     = 32'h0000_0000;
	localparam logic [31:0]        MODE_RST    = 32'h0000_0000;
	localparam logic [31:0]        SCALE_RST   = 32'h0001_0000;
	localparam logic [31:0]        RAMP_RST    = 32'h0000_03E8;
	localparam logic [31:0]        LAG_RST     = 32'h0000_0000;
	localparam logic signed [31:0] UPPER_RST   = 32'sh0001_0000;
	localparam logic signed [31:0] LOWER_RST   = 32'shFFFF_0000;
	localparam logic [31:0]        GAIN_RST    = 32'h0001_0000;
	// Register byte offsets
	localparam logic [11:0]        OFF_SRC     = 12'h000;
	localparam logic [11:0]        OFF_MODE    = 12'h004;
	localparam logic [11:0]        OFF_SC1     = 12'h008;
	localparam logic [11:0]        OFF_SC2     = 12'h00C;
	localparam logic [11:0]        OFF_T_UP    = 12'h010;
	localparam logic [11:0]        OFF_T_DN    = 12'h014;
	localparam logic [11:0]        OFF_SP_LAG  = 12'h018;
	localparam logic [11:0]        OFF_AC_LAG  = 12'h01C;
	localparam logic [11:0]        OFF_UPPER   = 12'h020;
	localparam logic [11:0]        OFF_LOWER   = 12'h024;
	localparam logic [11:0]        OFF_GAIN    = 12'h028;
	localparam logic [11:0]        OFF_IRQ_ST  = 12'h02C;
	localparam logic [11:0]        OFF_IRQ_MSK = 12'h030;
	localparam logic [11:0]        OFF_RAMPED  = 12'h034;
	localparam logic [11:0]        OFF_SP_SMTH = 12'h038;
	localparam logic [11:0]        OFF_AC_SMTH = 12'h03C;
	localparam logic [11:0]        OFF_AC_SCLD = 12'h040;
	localparam logic [11:0]        OFF_D_IN    = 12'h044;
	localparam logic [11:0]        OFF_LIVE    = 12'h048;
	// Field positions
	localparam int                 SRC_W       = 4;
	localparam int                 SRC1_LSB    = 0;
	localparam int                 SRC2_LSB    = 8;
	localparam int                 ACT_LSB     = 16;
	localparam int                 DERIV_BIT   = 0;
	localparam int                 FUNC_LSB    = 4;
	localparam int                 INV_BIT     = 8;
	localparam int                 IRQ_FAULT   = 0;
	localparam int                 IRQ_CYCLE   = 1;
	localparam logic [1:0]         FN_PASS     = 2'h0;
	localparam logic [1:0]         FN_ROOT     = 2'h1;
	localparam logic [1:0]         FN_SQUARE   = 2'h2;
	localparam logic [1:0]         FN_CUBE     = 2'h3;
	localparam logic [1:0]         RESP_OKAY   = 2'h0;
	localparam logic [1:0]         RESP_SLVERR = 2'h2;
	// Control cycle timing
	localparam int                 CLK_MHZ     = 200;
	localparam int                 CYCLE_US    = 1000;
	localparam int                 TICK_CYCLES = CYCLE_US * CLK_MHZ;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RAMP = 3'b001,
		ST_SPF  = 3'b011,
		ST_ACF  = 3'b010,
		ST_POST = 3'b110
	} psc_state_t;

	function automatic logic signed [31:0] psc_sat(input logic signed [63:0] v);
		if (v > 64'(SAT_MAX))
			return SAT_MAX;
		if (v < 64'(SAT_MIN))
			return SAT_MIN;
		return 32'(v);
	endfunction

	function automatic logic signed [31:0] psc_mulq(input logic signed [31:0] a,
	                                                input logic signed [31:0] b);
		logic signed [63:0] p;
		p = 64'(a) * 64'(b);
		return psc_sat(p >>> FRAC);
	endfunction

	function automatic logic [31:0] psc_wstrb(input logic [31:0] old,
	                                          input logic [31:0] d,
	                                          input logic [3:0]  s);
		logic [31:0] v;
		v = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				v[8*i +: 8] = d[8*i +: 8];
		return v;
	endfunction
endpackage
`default_nettype wire

// [hw/psc_div.sv]
// Serial signed-by-unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module psc_div #(
	parameter int W  = 48,
	parameter int DW = 24
) (
	// Clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// Request
	input  wire logic                start,
	input  wire logic signed [W-1:0] dividend,
	input  wire logic [DW-1:0]       divisor,
	// Answer
	output logic                     done,
	output logic signed [W-1:0]      quotient
);
	localparam int CW = $clog2(W);

	typedef struct packed {
		logic          busy;
		logic [CW-1:0] cnt;
		logic          neg;
		logic [DW-1:0] rem;
		logic [W-1:0]  quo;
		logic [DW-1:0] den;
		logic          done;
		logic [W-1:0]  q;
	} psc_div_t;

	psc_div_t r;
	psc_div_t next_r;
	logic [DW:0] sh;
	logic        ge;

	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		sh = {r.rem, r.quo[W-1]};
		ge = sh >= {1'b0, r.den};
		if (start)
		begin
			next_r.busy = 1'b1;
			next_r.cnt = '0;
			next_r.neg = dividend[W-1];
			next_r.quo = dividend[W-1] ? W'(-dividend) : dividend;
			next_r.rem = '0;
			next_r.den = divisor;
		end
		else if (r.busy)
		begin
			next_r.rem = ge ? DW'(sh - {1'b0, r.den}) : sh[DW-1:0];
			next_r.quo = {r.quo[W-2:0], ge};
			next_r.cnt = CW'(r.cnt + 1'b1);
			if (r.cnt == CW'(W - 1))
			begin
				// Truncation toward zero keeps a filter from overshooting its input
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.q = r.neg ? W'(-next_r.quo) : next_r.quo;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign done = r.done;
	assign quotient = $signed(r.q);
endmodule
`default_nettype wire

// [hw/psc_conditioner.sv]
// PID setpoint and actual-value conditioning with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module psc_conditioner #(
	parameter int NSRC        = 15,
	parameter int CYCLE_TICKS = psc_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// AXI4-Lite write
	input  wire logic [11:0]      s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0]      s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// Signal sources, source n at bits 32n-1..32n-32
	input  wire logic [NSRC*32-1:0] sig_in,
	// Conditioned outputs
	output logic [31:0]           ramped_setpoint_out,
	output logic [31:0]           smoothed_setpoint_out,
	output logic [31:0]           smoothed_actual_out,
	output logic [31:0]           scaled_actual_out,
	output logic [31:0]           derivative_input_out,
	output logic                  derivative_on_deviation,
	output logic                  actual_value_limit_fault,
	output logic                  irq
);
	import psc_pkg::*;

	typedef struct packed {
		logic [31:0]        src_sel;
		logic [31:0]        mode;
		logic [31:0]        sc1;
		logic [31:0]        sc2;
		logic [31:0]        t_up;
		logic [31:0]        t_dn;
		logic [31:0]        sp_lag;
		logic [31:0]        ac_lag;
		logic signed [31:0] upper;
		logic signed [31:0] lower;
		logic [31:0]        gain;
		logic [1:0]         irq_st;
		logic [1:0]         irq_msk;
		logic               aw_ok;
		logic               w_ok;
		logic [11:0]        awaddr;
		logic [31:0]        wdata;
		logic [3:0]         wstrb;
		logic               bvalid;
		logic [1:0]         bresp;
		logic               rvalid;
		logic [31:0]        rdata;
		logic [1:0]         rresp;
		psc_state_t         fsm;
		logic [31:0]        tick_cnt;
		logic               div_go;
		logic signed [47:0] div_a;
		logic [23:0]        div_b;
		logic signed [31:0] target;
		logic signed [31:0] ramp;
		logic [15:0]        ramp_lo;
		logic signed [31:0] sp_filt;
		logic signed [31:0] act_raw;
		logic signed [31:0] act_filt;
		logic signed [31:0] act_scl;
		logic signed [31:0] d_in;
		logic               fault;
	} psc_regs_t;

	psc_regs_t          r;
	psc_regs_t          next_r;
	logic               tick;
	logic               div_done;
	logic signed [47:0] div_q;
	logic [1:0]         wclr;
	logic [1:0]         irq_set;
	logic signed [63:0] rdiff;
	logic signed [47:0] ramp_full;
	logic signed [63:0] rstep;
	logic               rup;
	logic signed [31:0] post_gain;
	logic signed [31:0] post_sq;
	logic signed [31:0] post_root;
	logic signed [31:0] post_func;
	logic signed [31:0] post_out;
	logic signed [31:0] post_d;
	logic               post_fault;
	logic [1:0]         fn;

	function automatic logic signed [31:0] pick(input logic [SRC_W-1:0] s);
		// Source zero and unfitted sources read as zero
		if (s == '0 || int'(s) > NSRC)
			return '0;
		return $signed(sig_in[32*(int'(s)-1) +: 32]);
	endfunction

	function automatic logic [23:0] isqrt(input logic [47:0] v);
		logic [23:0] q;
		logic [23:0] t;
		q = '0;
		t = '0;
		for (int i = 23; i >= 0; i--)
		begin
			t = q | (24'h00_0001 << i);
			if (48'(t) * 48'(t) <= v)
				q = t;
		end
		return q;
	endfunction

	function automatic logic [23:0] lag_div(input logic [31:0] t);
		return 24'(t) + 24'h00_0001;
	endfunction

	function automatic logic [23:0] ramp_div(input logic [31:0] t);
		// A zero time gives a jump; the divider still runs to keep timing fixed
		return (t == '0) ? 24'h00_0001 : 24'(t);
	endfunction

	psc_div #(
		.W  (48),
		.DW (24)
	) u_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (r.div_go),
		.dividend (r.div_a),
		.divisor  (r.div_b),
		.done     (div_done),
		.quotient (div_q)
	);

	// Actual-value chain after the filter
	assign fn = r.mode[FUNC_LSB +: 2];
	assign post_fault = (r.act_filt > r.upper) || (r.act_filt < r.lower); // RQ11 RQ12
	assign post_gain = psc_mulq(r.act_filt, $signed(r.gain)); // RQ13
	assign post_sq = psc_mulq(post_gain, post_gain);
	assign post_root = post_gain[31] ? '0 : $signed({8'h00, isqrt({post_gain, 16'h0000})});
	assign post_func = (fn == FN_ROOT)   ? post_root : // RQ14
	                   (fn == FN_SQUARE) ? post_sq :
	                   (fn == FN_CUBE)   ? psc_mulq(post_sq, post_gain) : post_gain;
	assign post_out = r.mode[INV_BIT] ? psc_sat(-64'(post_func)) : post_func; // RQ15
	assign post_d = r.mode[DERIV_BIT] ? psc_sat(64'(r.sp_filt) - 64'(post_out)) : post_out; // RQ8

	assign ramp_full = $signed({r.ramp, r.ramp_lo});
	assign rdiff = (64'(r.target) <<< FRAC) - 64'(ramp_full);
	assign rstep = 64'(div_q);
	assign rup = rdiff > 0;
	assign tick = r.tick_cnt == 32'(CYCLE_TICKS - 1);

	always_comb
	begin
		next_r = r;
		next_r.div_go = 1'b0;
		wclr = '0;
		irq_set = '0;
		next_r.tick_cnt = tick ? '0 : r.tick_cnt + 32'h0000_0001;
		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_r.aw_ok = 1'b1;
			next_r.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_r.w_ok = 1'b1;
			next_r.wdata = s_axi_wdata;
			next_r.wstrb = s_axi_wstrb;
		end
		if (r.aw_ok && r.w_ok && !r.bvalid)
		begin
			next_r.bvalid = 1'b1;
			next_r.bresp = RESP_OKAY;
			unique case (r.awaddr)
				OFF_SRC:     next_r.src_sel = psc_wstrb(r.src_sel, r.wdata, r.wstrb);
				OFF_MODE:    next_r.mode = psc_wstrb(r.mode, r.wdata, r.wstrb);
				OFF_SC1:     next_r.sc1 = psc_wstrb(r.sc1, r.wdata, r.wstrb);
				OFF_SC2:     next_r.sc2 = psc_wstrb(r.sc2, r.wdata, r.wstrb);
				OFF_T_UP:    next_r.t_up = psc_wstrb(r.t_up, r.wdata, r.wstrb);
				OFF_T_DN:    next_r.t_dn = psc_wstrb(r.t_dn, r.wdata, r.wstrb);
				OFF_SP_LAG:  next_r.sp_lag = psc_wstrb(r.sp_lag, r.wdata, r.wstrb);
				OFF_AC_LAG:  next_r.ac_lag = psc_wstrb(r.ac_lag, r.wdata, r.wstrb);
				OFF_UPPER:   next_r.upper = $signed(psc_wstrb(r.upper, r.wdata, r.wstrb));
				OFF_LOWER:   next_r.lower = $signed(psc_wstrb(r.lower, r.wdata, r.wstrb));
				OFF_GAIN:    next_r.gain = psc_wstrb(r.gain, r.wdata, r.wstrb);
				OFF_IRQ_ST:  wclr = r.wstrb[0] ? r.wdata[1:0] : 2'h0;
				OFF_IRQ_MSK: next_r.irq_msk = r.wstrb[0] ? r.wdata[1:0] : r.irq_msk;
				OFF_RAMPED, OFF_SP_SMTH, OFF_AC_SMTH, OFF_AC_SCLD, OFF_D_IN, OFF_LIVE:
					next_r.bresp = RESP_OKAY;
				default:     next_r.bresp = RESP_SLVERR;
			endcase
		end
		if (r.bvalid && s_axi_bready)
		begin
			next_r.bvalid = 1'b0;
			next_r.aw_ok = 1'b0;
			next_r.w_ok = 1'b0;
		end
		// Read channel: data one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_r.rvalid = 1'b1;
			next_r.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				OFF_SRC:     next_r.rdata = r.src_sel;
				OFF_MODE:    next_r.rdata = r.mode;
				OFF_SC1:     next_r.rdata = r.sc1;
				OFF_SC2:     next_r.rdata = r.sc2;
				OFF_T_UP:    next_r.rdata = r.t_up;
				OFF_T_DN:    next_r.rdata = r.t_dn;
				OFF_SP_LAG:  next_r.rdata = r.sp_lag;
				OFF_AC_LAG:  next_r.rdata = r.ac_lag;
				OFF_UPPER:   next_r.rdata = r.upper;
				OFF_LOWER:   next_r.rdata = r.lower;
				OFF_GAIN:    next_r.rdata = r.gain;
				OFF_IRQ_ST:  next_r.rdata = {30'h0000_0000, r.irq_st};
				OFF_IRQ_MSK: next_r.rdata = {30'h0000_0000, r.irq_msk};
				OFF_RAMPED:  next_r.rdata = r.ramp; // RQ6
				OFF_SP_SMTH: next_r.rdata = r.sp_filt;
				OFF_AC_SMTH: next_r.rdata = r.act_filt;
				OFF_AC_SCLD: next_r.rdata = r.act_scl;
				OFF_D_IN:    next_r.rdata = r.d_in;
				OFF_LIVE:    next_r.rdata = {31'h0000_0000, r.fault};
				default:
				begin
					next_r.rdata = '0;
					next_r.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (r.rvalid && s_axi_rready)
			next_r.rvalid = 1'b0;
		// One pass of the chain per control cycle; a late tick is skipped
		unique case (r.fsm)
			ST_IDLE:
				if (tick)
				begin
					next_r.target = psc_sat(64'(psc_mulq(pick(r.src_sel[SRC1_LSB +: SRC_W]), // RQ1 RQ2
					                                     $signed(r.sc1)))
					                      + 64'(psc_mulq(pick(r.src_sel[SRC2_LSB +: SRC_W]), // RQ3
					                                     $signed(r.sc2)))); // RQ17
					next_r.act_raw = pick(r.src_sel[ACT_LSB +: SRC_W]); // RQ9
					next_r.div_a = 48'(FULL_SCALE) <<< FRAC;
					next_r.div_b = (next_r.target > r.ramp) ? ramp_div(r.t_up) : ramp_div(r.t_dn);
					next_r.div_go = 1'b1;
					next_r.fsm = ST_RAMP;
				end
			ST_RAMP:
				if (div_done)
				begin
					// Step is 100 % over the ramp time, held with extra fraction bits so
					// that ramps of hundreds of seconds still advance every control cycle
					if ((rup ? r.t_up : r.t_dn) == '0 || (rup ? rdiff : -rdiff) <= rstep)
					begin
						next_r.ramp = r.target; // RQ4 RQ5
						next_r.ramp_lo = '0;
					end
					else if (rup)
						{next_r.ramp, next_r.ramp_lo} = 48'(64'(ramp_full) + rstep); // RQ4
					else
						{next_r.ramp, next_r.ramp_lo} = 48'(64'(ramp_full) - rstep); // RQ5
					next_r.div_a = 48'(next_r.ramp) - 48'(r.sp_filt);
					next_r.div_b = lag_div(r.sp_lag);
					next_r.div_go = 1'b1;
					next_r.fsm = ST_SPF;
				end
			ST_SPF:
				if (div_done)
				begin
					next_r.sp_filt = psc_sat(64'(r.sp_filt) + 64'(div_q)); // RQ7
					next_r.div_a = 48'(r.act_raw) - 48'(r.act_filt);
					next_r.div_b = lag_div(r.ac_lag);
					next_r.div_go = 1'b1;
					next_r.fsm = ST_ACF;
				end
			ST_ACF:
				if (div_done)
				begin
					next_r.act_filt = psc_sat(64'(r.act_filt) + 64'(div_q)); // RQ10
					next_r.fsm = ST_POST;
				end
			ST_POST:
			begin
				next_r.fault = post_fault; // RQ11 RQ12
				next_r.act_scl = post_out; // RQ17
				next_r.d_in = post_d; // RQ8
				irq_set[IRQ_FAULT] = post_fault;
				irq_set[IRQ_CYCLE] = 1'b1;
				next_r.fsm = ST_IDLE;
			end
			default:
				next_r.fsm = ST_IDLE;
		endcase
		// A new event wins over a clear in the same cycle
		next_r.irq_st = (r.irq_st & ~wclr) | irq_set;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r <= '0;
			r.src_sel <= SRC_RST;
			r.mode <= MODE_RST;
			r.sc1 <= SCALE_RST;
			r.sc2 <= SCALE_RST;
			r.t_up <= RAMP_RST;
			r.t_dn <= RAMP_RST;
			r.sp_lag <= LAG_RST;
			r.ac_lag <= LAG_RST;
			r.upper <= UPPER_RST;
			r.lower <= LOWER_RST;
			r.gain <= GAIN_RST;
			r.fsm <= ST_IDLE;
		end
		else
			r <= next_r;
	end

	assign s_axi_awready = !r.aw_ok && !r.bvalid;
	assign s_axi_wready = !r.w_ok && !r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign ramped_setpoint_out = r.ramp; // RQ6
	assign smoothed_setpoint_out = r.sp_filt;
	assign smoothed_actual_out = r.act_filt;
	assign scaled_actual_out = r.act_scl;
	assign derivative_input_out = r.d_in;
	assign derivative_on_deviation = r.mode[DERIV_BIT];
	assign actual_value_limit_fault = r.fault;
	assign irq = |(r.irq_st & r.irq_msk);

	sequence s_post;
		r.fsm == ST_POST;
	endsequence

	sequence s_ramp_done;
		r.fsm == ST_RAMP && div_done;
	endsequence

	property p_ramp_up;
		@(posedge aclk) disable iff (!aresetn)
		s_ramp_done ##0 (r.target > r.ramp)
		|=> (ramp_full > $past(ramp_full)) && (r.ramp <= r.target);
	endproperty
	a_ramp_up: assert property (p_ramp_up) else $error("ramp did not rise toward target"); // RQ4

	property p_ramp_dn;
		@(posedge aclk) disable iff (!aresetn)
		s_ramp_done ##0 (r.target < r.ramp)
		|=> (ramp_full < $past(ramp_full)) && (r.ramp >= r.target);
	endproperty
	a_ramp_dn: assert property (p_ramp_dn) else $error("ramp did not fall toward target"); // RQ5

	property p_sp_nolag;
		@(posedge aclk) disable iff (!aresetn)
		(r.fsm == ST_SPF && div_done && r.sp_lag == '0) |=> (r.sp_filt == r.ramp);
	endproperty
	a_sp_nolag: assert property (p_sp_nolag) else $error("setpoint lag zero not transparent"); // RQ7

	property p_ac_nolag;
		@(posedge aclk) disable iff (!aresetn)
		(r.fsm == ST_ACF && div_done && r.ac_lag == '0) |=> (r.act_filt == r.act_raw);
	endproperty
	a_ac_nolag: assert property (p_ac_nolag) else $error("actual lag zero not transparent"); // RQ10

	property p_upper;
		@(posedge aclk) disable iff (!aresetn)
		s_post ##0 (r.act_filt > r.upper) |=> r.fault && r.irq_st[IRQ_FAULT];
	endproperty
	a_upper: assert property (p_upper) else $error("no fault above upper limit"); // RQ11

	property p_lower;
		@(posedge aclk) disable iff (!aresetn)
		s_post ##0 (r.act_filt < r.lower) |=> r.fault;
	endproperty
	a_lower: assert property (p_lower) else $error("no fault below lower limit"); // RQ12

	property p_unity;
		@(posedge aclk) disable iff (!aresetn)
		s_post ##0 (r.gain == GAIN_RST && fn == FN_PASS && !r.mode[INV_BIT])
		|=> (scaled_actual_out == $past(r.act_filt));
	endproperty
	a_unity: assert property (p_unity) else $error("unity gain changed the value"); // RQ13

	property p_invert;
		@(posedge aclk) disable iff (!aresetn)
		s_post ##0 (r.mode[INV_BIT] && post_func != SAT_MIN) |=> (r.act_scl == -$past(post_func));
	endproperty
	a_invert: assert property (p_invert) else $error("inversion not applied"); // RQ15

	property p_dplace;
		@(posedge aclk) disable iff (!aresetn)
		s_post |=> (r.d_in == ($past(r.mode[DERIV_BIT])
		                       ? psc_sat(64'(r.sp_filt) - 64'(r.act_scl)) : r.act_scl));
	endproperty
	a_dplace: assert property (p_dplace) else $error("derivative input misplaced"); // RQ8
endmodule
`default_nettype wire

// [testbench/psc_src_model.sv]
// Model of the setpoint sources and the process sensor on the signal bus
`timescale 1ns/1ps
`default_nettype none
module psc_src_model #(
	parameter int NSRC = 15
) (
	// Clock
	input  wire logic              aclk,
	// Levels chosen by the bench
	input  wire logic [31:0]       sp_one,
	input  wire logic [31:0]       sp_two,
	input  wire logic [31:0]       sensor,
	// Signal bus
	output logic [NSRC*32-1:0]     sig_in
);
	logic [31:0] spin = 32'h0000_0000;

	always_ff @(posedge aclk)
	begin
		spin <= spin + 32'h0001_3579;
		// Unused sources wander so a wrong select never reads a quiet zero
		for (int i = 0; i < NSRC; i++)
			sig_in[32*i +: 32] <= spin ^ 32'(i);
		sig_in[31:0] <= sp_one;
		sig_in[63:32] <= sp_two;
		sig_in[95:64] <= sensor;
	end
endmodule
`default_nettype wire

// [testbench/psc_conditioner_tb.sv]
// Self-checking bench of the setpoint and actual-value conditioner
`timescale 1ns/1ps
`default_nettype none
module psc_conditioner_tb;
	import psc_pkg::*;
	logic aclk, aresetn, irq, actual_value_limit_fault, derivative_on_deviation;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, ramped_setpoint_out, smoothed_setpoint_out, v, e;
	logic [31:0] smoothed_actual_out, scaled_actual_out, derivative_input_out, s1, s2, sa;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [479:0] sig_in;
	int n_mismatch, samples_checked;
	logic [11:0] roff [12] = '{OFF_SRC, OFF_MODE, OFF_SC1, OFF_SC2, OFF_T_UP, OFF_T_DN,
		OFF_SP_LAG, OFF_AC_LAG, OFF_UPPER, OFF_LOWER, OFF_GAIN, OFF_IRQ_MSK};
	logic [31:0] rexp [12] = '{SRC_RST, MODE_RST, SCALE_RST, SCALE_RST, RAMP_RST, RAMP_RST,
		LAG_RST, LAG_RST, UPPER_RST, LOWER_RST, GAIN_RST, 32'h0000_0000};
	logic [31:0] ftab [4] = '{32'h0000_8000, 32'h0000_B504, 32'h0000_4000, 32'h0000_2000};

	psc_src_model psc_src_model_inst (.aclk, .sp_one(s1), .sp_two(s2), .sensor(sa), .sig_in);
	psc_conditioner #(.CYCLE_TICKS(400)) psc_conditioner_inst (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .sig_in, .ramped_setpoint_out, .smoothed_setpoint_out,
		.smoothed_actual_out, .scaled_actual_out, .derivative_input_out,
		.derivative_on_deviation, .actual_value_limit_fault, .irq);

	always #2.5 aclk = ~aclk;

	task automatic close_out;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic tmo(inout int n);
		n++;
		if (n > 500)
		begin
			n_mismatch++;
			close_out();
		end
	endtask

	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	// Ready and response are judged 1 ns after the edge, where they have settled
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw, w, b;
		int n;
		n = 0;
		b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!b)
		begin
			#1;
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
			tmo(n);
		end
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic ar, g;
		int n;
		n = 0;
		g = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!g)
		begin
			#1;
			ar = s_axi_arvalid && s_axi_arready;
			g = s_axi_rvalid;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
			tmo(n);
		end
	endtask

	// Clears the pass-done flag and waits for the next control pass to finish
	task automatic pass;
		logic [31:0] st;
		int n;
		n = 0;
		st = '0;
		wr(OFF_IRQ_ST, 32'h0000_0002);
		while (!st[IRQ_CYCLE])
		begin
			rd(OFF_IRQ_ST, st);
			tmo(n);
		end
	endtask

	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s1, s2, sa} = '0;
		{n_mismatch, samples_checked} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			rd(roff[i], v);
			chk("reset value", v, rexp[i]);
		end
		rd(12'h0FC, v);
		chk("unmapped read", {30'h0, resp}, {30'h0, RESP_SLVERR});
		wr(12'h0FC, 32'h0000_0001);
		chk("unmapped write", {30'h0, resp}, {30'h0, RESP_SLVERR});
		s1 <= 32'h0001_0000;
		s2 <= 32'h0000_4000;
		sa <= 32'h0000_8000;
		wr(OFF_SRC, 32'h0003_0201);
		wr(OFF_SC1, 32'h0000_8000);
		wr(OFF_T_UP, 32'h0000_0000);
		wr(OFF_T_DN, 32'h0000_0004);
		pass();
		chk("ramp", ramped_setpoint_out, 32'h0000_C000);
		rd(OFF_RAMPED, v);
		chk("ramp reg", v, 32'h0000_C000);
		chk("smoothed sp", smoothed_setpoint_out, 32'h0000_C000);
		chk("smoothed act", smoothed_actual_out, 32'h0000_8000);
		s1 <= 32'h0000_0000;
		pass();
		chk("ramp down", ramped_setpoint_out, 32'h0000_8000);
		pass();
		pass();
		chk("ramp end", ramped_setpoint_out, 32'h0000_4000);
		wr(OFF_T_UP, 32'h0000_0004);
		s1 <= 32'h0001_0000;
		pass();
		chk("ramp up", ramped_setpoint_out, 32'h0000_8000);
		wr(OFF_T_UP, 32'h0000_0000);
		wr(OFF_GAIN, 32'h0002_0000);
		sa <= 32'h0000_4000;
		// Inversion paired with deviation mode; choice is the operator's
		for (int i = 0; i < 8; i++)
		begin
			wr(OFF_MODE, {23'h0, i[2], 2'h0, i[1:0], 3'h0, i[2]});
			pass();
			e = i[2] ? -ftab[i[1:0]] : ftab[i[1:0]];
			chk("scaled act", scaled_actual_out, e);
			chk("d input", derivative_input_out, i[2] ? 32'h0000_C000 - e : e);
			chk("d select", {31'h0, derivative_on_deviation}, {31'h0, i[2]});
		end
		sa <= 32'h0001_8000;
		pass();
		chk("fault high", {31'h0, actual_value_limit_fault}, 32'h0000_0001);
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		wr(OFF_IRQ_MSK, 32'h0000_0001);
		chk("irq on", {31'h0, irq}, 32'h0000_0001);
		sa <= 32'hFFFE_8000;
		pass();
		chk("fault low", {31'h0, actual_value_limit_fault}, 32'h0000_0001);
		sa <= 32'h0000_0000;
		pass();
		chk("fault gone", {31'h0, actual_value_limit_fault}, 32'h0000_0000);
		chk("irq sticky", {31'h0, irq}, 32'h0000_0001);
		wr(OFF_IRQ_ST, 32'h0000_0001);
		chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
		wr(OFF_SP_LAG, 32'h0000_0001);
		wr(OFF_AC_LAG, 32'h0000_0001);
		s1 <= 32'h0000_0000;
		sa <= 32'h0001_0000;
		pass();
		chk("ramp lagged", ramped_setpoint_out, 32'h0000_8000);
		chk("lagged sp", smoothed_setpoint_out, 32'h0000_A000);
		chk("lagged act", smoothed_actual_out, 32'h0000_8000);
		close_out();
	end
endmodule
`default_nettype wire
